// ===== inc/tx_coding_pkg.sv
package tx_coding_pkg;

  // clock rate of ref_clk_in
  localparam int unsigned CLK_HZ = 20_000_000;

  // register map
  localparam logic [7:0] ADDR_FRAMING = 8'h48;
  localparam logic [7:0] ADDR_AUX = 8'h49;
  localparam logic [7:0] ADDR_CODING = 8'h4a;

  // framing control: writable bits, reserved bits stay zero
  localparam logic [7:0] FRAMING_WR_MASK = 8'hab;
  localparam logic [7:0] FRAMING_RST = 8'h00;
  localparam logic [7:0] CODING_RST = 8'h00;

  // auxiliary control and status
  localparam int unsigned AUX_PARITY_EN = 0;
  localparam int unsigned AUX_STOP_EN = 1;
  localparam int unsigned AUX_SC_EN = 2;
  localparam int unsigned AUX_BUSY = 7;
  localparam logic [7:0] AUX_WR_MASK = 8'h07;
  localparam logic [7:0] AUX_RST = 8'h00;

  // coding scheme codes
  localparam logic [3:0] SCH_PLAIN = 4'h0;
  localparam logic [3:0] SCH_COLLIDER = 4'h1;
  localparam logic [3:0] SCH_RZ_FIRST = 4'h4;
  localparam logic [3:0] SCH_RZ_LAST = 4'h7;
  localparam logic [3:0] SCH_1OF4 = 4'h8;
  localparam logic [3:0] SCH_256 = 4'h9;
  localparam logic [3:0] SCH_256_SILENT = 4'ha;
  localparam logic [3:0] SCH_256_LAST = 4'hb;
  localparam logic [3:0] SCH_PIE = 4'hc;

  // bit-stream rates and their codes
  localparam int unsigned RATE_26_HZ = 26_000;
  localparam int unsigned RATE_53_HZ = 53_000;
  localparam int unsigned RATE_106_HZ = 106_000;
  localparam int unsigned RATE_212_HZ = 212_000;
  localparam int unsigned RATE_424_HZ = 424_000;
  localparam int unsigned RATE_848_HZ = 848_000;
  localparam logic [2:0] RATE_CODE_53 = 3'h3;
  localparam logic [2:0] RATE_CODE_106 = 3'h4;
  localparam logic [2:0] RATE_CODE_212 = 3'h5;
  localparam logic [2:0] RATE_CODE_424 = 3'h6;
  localparam logic [2:0] RATE_CODE_848 = 3'h7;

  // quarter-bit reload counts, rounded down
  localparam logic [7:0] QTR_RELOAD_26 = 8'(CLK_HZ / (RATE_26_HZ * 4) - 1);
  localparam logic [7:0] QTR_RELOAD_53 = 8'(CLK_HZ / (RATE_53_HZ * 4) - 1);
  localparam logic [7:0] QTR_RELOAD_106 = 8'(CLK_HZ / (RATE_106_HZ * 4) - 1);
  localparam logic [7:0] QTR_RELOAD_212 = 8'(CLK_HZ / (RATE_212_HZ * 4) - 1);
  localparam logic [7:0] QTR_RELOAD_424 = 8'(CLK_HZ / (RATE_424_HZ * 4) - 1);
  localparam logic [7:0] QTR_RELOAD_848 = 8'(CLK_HZ / (RATE_848_HZ * 4) - 1);

  // subcarrier half-period reload counts
  localparam int unsigned SC_424_HZ = 424_000;
  localparam int unsigned SC_848_HZ = 848_000;
  localparam logic [4:0] SC_RELOAD_424 = 5'(CLK_HZ / (SC_424_HZ * 2) - 1);
  localparam logic [4:0] SC_RELOAD_848 = 5'(CLK_HZ / (SC_848_HZ * 2) - 1);

  // sequencing limits, in quarter bits and items
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [9:0] SUB_LAST_BIT = 10'h003;
  localparam logic [9:0] SUB_LAST_PIE0 = 10'h001;
  localparam logic [9:0] SUB_LAST_1OF4 = 10'h00f;
  localparam logic [9:0] SUB_LAST_256 = 10'h3ff;
  localparam logic [3:0] IDX_LAST_1OF4 = 4'h3;
  localparam logic [7:0] SLOT_LAST = 8'hff;

  typedef struct packed {
    logic tx_high_bit_leads;
    logic rfu6;
    logic tx_odd_parity_select;
    logic rfu4;
    logic tx_stop_level;
    logic rfu2;
    logic tx_start_level;
    logic tx_start_insert;
  } framing_cfg_s;

  typedef struct packed {
    logic [3:0] coding_scheme_select;
    logic subcarrier_rate_select;
    logic [2:0] bitstream_rate_select;
  } coding_cfg_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } tx_state_e;

endpackage : tx_coding_pkg

// ===== rtl/tx_bit_coder.sv
// Overview of operation
// - bit 7 set sends data high bit first, cleared sends low bit first.
// - bit 5 set makes odd parity, cleared makes even parity.
// - bit 3 gives the stop bit level, zero or one.
// - bit 1 gives the start bit level, zero or one.
// - bit 0 set inserts a start bit, cleared sends none.
// - scheme 0h sends plain bits, 1h passes the collider stream as is.
// - schemes 4h to 7h return to zero, pulse in quarter one to four.
// - scheme 8h sends bit pairs as one-of-four pulse positions.
// - scheme 9h sends each byte as one-of-256 pulse position.
// - scheme Ah sends a zero byte with no pulse at all.
// - scheme Bh sends a zero byte as a pulse in the last slot.
// - scheme Ch sends pulse interval encoding.
// - bit 3 picks a 424 kHz or 848 kHz subcarrier.
// - subcarrier rate only matters when the subcarrier envelope is on.
// - bits 2 to 0 pick the bit-stream rate from 26 to 848 kHz.
`timescale 1ns/100ps
`default_nettype none
module tx_bit_coder
  import tx_coding_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [7:0] byte_in,
  input wire logic byte_valid_in,
  output logic byte_ready_out,
  output logic tx_env_out,
  output logic tx_active_out
);

  framing_cfg_s framing_q;
  coding_cfg_s coding_q;
  logic [7:0] aux_q;
  logic [7:0] rdata_q;
  tx_state_e state_q;
  logic [7:0] byte_q;
  logic [3:0] idx_q;
  logic [9:0] sub_q;
  logic [7:0] qcnt_q;
  logic [4:0] sc_cnt_q;
  logic sc_phase_q;
  logic env_q;

  // register decode
  wire sel_framing = reg_addr_in == ADDR_FRAMING;
  wire sel_aux = reg_addr_in == ADDR_AUX;
  wire sel_coding = reg_addr_in == ADDR_CODING;
  wire busy = state_q == ST_SEND;
  wire [7:0] aux_rd = (aux_q & AUX_WR_MASK) | (8'(busy) << AUX_BUSY);
  wire [7:0] rd_mux = sel_framing ? framing_q :
                      sel_coding ? coding_q :
                      sel_aux ? aux_rd : 8'h00;

  // register writes; reserved framing bits are masked so they read zero
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      framing_q <= FRAMING_RST;
      coding_q <= CODING_RST;
      aux_q <= AUX_RST;
    end else if (clk_en_in && reg_wr_in) begin
      if (sel_framing) framing_q <= reg_wdata_in & FRAMING_WR_MASK;
      if (sel_coding) coding_q <= reg_wdata_in;
      if (sel_aux) aux_q <= reg_wdata_in & AUX_WR_MASK;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= 8'h00;
    end else if (clk_en_in) begin
      rdata_q <= reg_rd_in ? rd_mux : 8'h00;
    end
  end

  // configuration fields
  wire [3:0] scheme = coding_q.coding_scheme_select;
  wire parity_en = aux_q[AUX_PARITY_EN];
  wire stop_en = aux_q[AUX_STOP_EN];
  wire sc_en = aux_q[AUX_SC_EN];
  wire start_en = framing_q.tx_start_insert;
  wire is_rz = (scheme >= SCH_RZ_FIRST) && (scheme <= SCH_RZ_LAST);
  wire is_1of4 = scheme == SCH_1OF4;
  wire is_256 = (scheme == SCH_256) || (scheme == SCH_256_SILENT) || (scheme == SCH_256_LAST);
  wire is_pie = scheme == SCH_PIE;
  // reserved schemes fall back to plain bits rather than going silent
  wire is_framed = !is_1of4 && !is_256;

  // quarter-bit reload per rate; reserved codes run at the slowest rate
  wire [2:0] rate = coding_q.bitstream_rate_select;
  wire [7:0] qtr_reload = (rate == RATE_CODE_848) ? QTR_RELOAD_848 :
                          (rate == RATE_CODE_424) ? QTR_RELOAD_424 :
                          (rate == RATE_CODE_212) ? QTR_RELOAD_212 :
                          (rate == RATE_CODE_106) ? QTR_RELOAD_106 :
                          (rate == RATE_CODE_53) ? QTR_RELOAD_53 : QTR_RELOAD_26;
  wire qtick = clk_en_in && busy && (qcnt_q == 8'h00);

  // data bit j of the byte in sending order
  function automatic logic data_bit(input logic [7:0] b, input logic msb, input logic [3:0] j);
    logic [2:0] k;
    k = j[2:0];
    return msb ? b[3'h7 - k] : b[k];
  endfunction

  // framed items: optional start, data, optional parity, optional stop
  wire [3:0] frame_len = DATA_BITS + 4'(start_en) + 4'(parity_en) + 4'(stop_en);
  wire [3:0] data_idx = idx_q - 4'(start_en);
  wire in_start = start_en && (idx_q == 4'h0);
  wire in_data = !in_start && (data_idx < DATA_BITS);
  wire in_parity = !in_start && parity_en && (data_idx == DATA_BITS);
  wire parity_bit = (^byte_q) ^ framing_q.tx_odd_parity_select;
  wire cur_bit = in_start ? framing_q.tx_start_level :
                 in_data ? data_bit(byte_q, framing_q.tx_high_bit_leads, data_idx) :
                 in_parity ? parity_bit :
                 framing_q.tx_stop_level;

  // pulse-position values
  wire [3:0] pair_lo = {idx_q[2:0], 1'b0};
  wire [3:0] pair_hi = {idx_q[2:0], 1'b1};
  wire [1:0] pair_val = {data_bit(byte_q, framing_q.tx_high_bit_leads, pair_hi),
                         data_bit(byte_q, framing_q.tx_high_bit_leads, pair_lo)};
  wire [1:0] rz_slot = 2'(scheme - SCH_RZ_FIRST);
  wire [7:0] slot256 = (scheme == SCH_256_LAST && byte_q == 8'h00) ? SLOT_LAST : byte_q;
  wire silent0 = (scheme == SCH_256_SILENT) && (byte_q == 8'h00);

  // sequence limits per scheme
  wire [9:0] sub_last = is_256 ? SUB_LAST_256 :
                        is_1of4 ? SUB_LAST_1OF4 :
                        (is_pie && !cur_bit) ? SUB_LAST_PIE0 : SUB_LAST_BIT;
  wire [3:0] idx_last = is_256 ? 4'h0 : is_1of4 ? IDX_LAST_1OF4 : frame_len - 4'h1;
  wire item_end = sub_q == sub_last;
  wire byte_end = item_end && (idx_q == idx_last);

  // modulation level for the current quarter
  wire lvl_rz = cur_bit && (sub_q[1:0] == rz_slot);
  wire lvl_pie = sub_q != sub_last;
  wire lvl_1of4 = sub_q[3:2] == pair_val;
  wire lvl_256 = (sub_q[9:2] == slot256) && !silent0;
  wire level = is_256 ? lvl_256 :
               is_1of4 ? lvl_1of4 :
               is_pie ? lvl_pie :
               is_rz ? lvl_rz : cur_bit;

  // the envelope is gated by the subcarrier only while it is enabled
  wire env_d = busy && (sc_en ? (level && sc_phase_q) : level);
  wire [4:0] sc_reload = coding_q.subcarrier_rate_select ? SC_RELOAD_848 : SC_RELOAD_424;

  // a new byte is taken when idle or at the last quarter of the current one
  assign byte_ready_out = clk_en_in && ((state_q == ST_IDLE) || (qtick && byte_end));
  wire accept = byte_ready_out && byte_valid_in;

  // sequencer state; back-to-back bytes run without a gap
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_IDLE;
      byte_q <= 8'h00;
      idx_q <= 4'h0;
      sub_q <= 10'h000;
    end else if (accept) begin
      state_q <= ST_SEND;
      byte_q <= byte_in;
      idx_q <= 4'h0;
      sub_q <= 10'h000;
    end else if (qtick) begin
      case (state_q)
        ST_SEND: begin
          if (byte_end) begin
            state_q <= ST_IDLE;
          end else if (item_end) begin
            idx_q <= idx_q + 4'h1;
            sub_q <= 10'h000;
          end else begin
            sub_q <= sub_q + 10'h001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // quarter-bit timer; reload on accept so every byte starts on a full quarter
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      qcnt_q <= 8'h00;
    end else if (accept || qtick) begin
      qcnt_q <= qtr_reload;
    end else if (clk_en_in && busy) begin
      qcnt_q <= qcnt_q - 8'h01;
    end
  end

  // subcarrier phase; free-running while busy, so its phase is not bit aligned
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sc_cnt_q <= 5'h00;
      sc_phase_q <= 1'b0;
    end else if (clk_en_in) begin
      if (!busy) begin
        sc_cnt_q <= sc_reload;
        sc_phase_q <= 1'b1;
      end else if (sc_cnt_q == 5'h00) begin
        sc_cnt_q <= sc_reload;
        sc_phase_q <= !sc_phase_q;
      end else begin
        sc_cnt_q <= sc_cnt_q - 5'h01;
      end
    end
  end

  // registered envelope costs one cycle of latency but keeps the pin glitch free
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      env_q <= 1'b0;
    end else if (clk_en_in) begin
      env_q <= env_d;
    end
  end

  assign tx_env_out = env_q;
  assign tx_active_out = busy;
  assign reg_rdata_out = rdata_q;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  // first data item follows the bit-order control
  chk_first_data_order: assert property (
    busy && is_framed && (idx_q == 4'(start_en)) |->
      cur_bit == (framing_q.tx_high_bit_leads ? byte_q[7] : byte_q[0]))
    else $error("first data bit not in the selected order");

  // data and parity together hold the selected sense
  chk_parity_sense: assert property (
    busy && is_framed && in_parity |-> (^{byte_q, cur_bit}) == framing_q.tx_odd_parity_select)
    else $error("parity bit has the wrong sense");

  // the last framed item is the stop bit when it is enabled
  chk_stop_bit_level: assert property (
    busy && is_framed && stop_en && (idx_q == frame_len - 4'h1) |->
      cur_bit == framing_q.tx_stop_level)
    else $error("stop bit level wrong");

  // the first framed item is the start bit when it is inserted
  chk_start_bit_level: assert property (
    busy && is_framed && start_en && (idx_q == 4'h0) |-> cur_bit == framing_q.tx_start_level)
    else $error("start bit level wrong");

  // an inserted start bit really reaches the pin at its level
  chk_start_insert: assert property (
    clk_en_in && busy && start_en && (scheme == SCH_PLAIN) && !sc_en && (idx_q == 4'h0) |=>
      tx_env_out == framing_q.tx_start_level)
    else $error("start bit missing from the envelope");

  // plain coding puts each bit on the pin one cycle later
  chk_plain_follows: assert property (
    clk_en_in && busy && !sc_en && (scheme == SCH_PLAIN) |=> tx_env_out == $past(cur_bit))
    else $error("plain envelope does not follow the bit");

  // the collider stream goes out without any extra coding
  chk_collider_follows: assert property (
    clk_en_in && busy && !sc_en && (scheme == SCH_COLLIDER) |=> tx_env_out == $past(cur_bit))
    else $error("collider envelope does not follow the bit");

  // return to zero: quiet outside the pulse quarter
  chk_rz_quiet: assert property (
    clk_en_in && busy && is_rz && !sc_en && (sub_q[1:0] != rz_slot) |=> !tx_env_out)
    else $error("return to zero pulse outside its quarter");

  // return to zero: a one bit pulses in its own quarter
  chk_rz_pulse: assert property (
    clk_en_in && busy && is_rz && !sc_en && cur_bit && (sub_q[1:0] == rz_slot) |=>
      tx_env_out)
    else $error("return to zero one bit without its pulse");

  // one-of-four: quiet outside the symbol slot
  chk_pair_quiet: assert property (
    clk_en_in && busy && is_1of4 && !sc_en && (sub_q[3:2] != pair_val) |=> !tx_env_out)
    else $error("one-of-four pulse outside its slot");

  // one-of-four: the symbol slot carries the pulse
  chk_pair_pulse: assert property (
    clk_en_in && busy && is_1of4 && !sc_en && (sub_q[3:2] == pair_val) |=> tx_env_out)
    else $error("one-of-four slot without a pulse");

  // one-of-256: pulse only in the slot named by the byte itself
  chk_byte_slot: assert property (
    clk_en_in && busy && (scheme == SCH_256) && !sc_en && (sub_q[9:2] != byte_q) |=>
      !tx_env_out)
    else $error("one-of-256 pulse outside its slot");

  // silent variant: a zero byte never modulates the pin
  chk_zero_silent: assert property (
    clk_en_in && busy && (scheme == SCH_256_SILENT) && (byte_q == 8'h00) |=> !tx_env_out)
    else $error("zero byte modulated in silent scheme");

  // last-slot variant: a zero byte pulses only in the last slot
  chk_zero_last_slot: assert property (
    clk_en_in && busy && !sc_en && (scheme == SCH_256_LAST) && (byte_q == 8'h00) |=>
      tx_env_out == ($past(sub_q) >= {SLOT_LAST, 2'h0}))
    else $error("zero byte pulse not in the last slot");

  // pulse interval items always end on a low quarter
  chk_pie_gap: assert property (
    clk_en_in && busy && is_pie && !sc_en && item_end |=> !tx_env_out)
    else $error("pulse interval item without its low quarter");

  // each subcarrier half period restarts from the selected rate
  chk_sc_reload: assert property (
    clk_en_in && busy && (sc_cnt_q == 5'h00) |=>
      sc_cnt_q == (coding_q.subcarrier_rate_select ? SC_RELOAD_848 : SC_RELOAD_424))
    else $error("subcarrier half period not at the selected rate");

  // even the fastest rate keeps quarter ticks five cycles apart
  chk_quarter_spacing: assert property (
    qtick |=> !qtick [*4])
    else $error("quarter ticks closer than the fastest rate allows");

  // the item right after the last data bit carries the parity
  chk_parity_place: assert property (
    clk_en_in && busy && (scheme == SCH_PLAIN) && !sc_en && parity_en &&
      (idx_q == DATA_BITS + 4'(start_en)) |=>
      tx_env_out == ((^$past(byte_q)) ^ framing_q.tx_odd_parity_select))
    else $error("parity item not after the data bits");

  // no envelope while idle, so a subcarrier rate alone never modulates
  chk_idle_silent: assert property (
    clk_en_in && !busy |=> !tx_env_out)
    else $error("envelope active while idle");

  // main scenarios
  cov_plain_byte: cover property (accept ##1 busy && (scheme == SCH_PLAIN));
  cov_back_to_back: cover property (accept && busy);
  cov_pie_send: cover property (busy && is_pie && qtick && byte_end);
  cov_256_pulse: cover property (busy && is_256 && level);
  cov_one_of_four: cover property (busy && is_1of4 && qtick && byte_end);

endmodule : tx_bit_coder
`default_nettype wire

// ===== tb/rf_card_model.sv
`timescale 1ns/100ps
`default_nettype none
// card on the far side of the field: only listens, so it drives nothing back
module rf_card_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic env_in,
  input wire logic active_in
);
  logic act_q;
  logic wave[$];
  // envelope lags active by one cycle, so recording runs one cycle behind it
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      act_q <= 1'b0;
    end else begin
      act_q <= active_in;
      if (act_q) begin
        wave.push_back(env_in);
      end
    end
  end
endmodule : rf_card_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tx_coding_pkg::*;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic [7:0] byte_in = 8'h00;
  logic byte_valid_in = 1'b0;
  logic byte_ready_out;
  logic tx_env_out;
  logic tx_active_out;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  // bench copies of the three control registers
  logic [7:0] fr = 8'h00;
  logic [7:0] aux = 8'h00;
  logic [7:0] cd = 8'h00;
  logic ex[$];
  logic [3:0] sch[7] = '{SCH_PLAIN, SCH_COLLIDER, 4'h5, 4'h6, SCH_RZ_FIRST, SCH_RZ_LAST, SCH_PIE};

  tx_bit_coder tx_bit_coder_i (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .clk_en_in(clk_en_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .byte_in(byte_in),
    .byte_valid_in(byte_valid_in),
    .byte_ready_out(byte_ready_out),
    .tx_env_out(tx_env_out),
    .tx_active_out(tx_active_out)
  );
  rf_card_model rf_card_model_i (
    .clk_in(ref_clk_in),
    .rst_n_in(arst_n_in),
    .env_in(tx_env_out),
    .active_in(tx_active_out)
  );

  // 20 MHz
  always #25 ref_clk_in = ~ref_clk_in;

  // the slowest 1-of-256 bytes dominate, the ceiling leaves about double margin
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      $display("FAIL %0t run did not finish", $time);
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t register got %h exp %h", $time, got, exp);
    end
  endtask : cmp8

  // one sample on the third cycle of every quarter bit
  task automatic cmp_wave(input int q);
    int bad;
    bad = 0;
    // every busy cycle is recorded, so the length must match exactly
    if (rf_card_model_i.wave.size() != ex.size() * q) begin
      bad++;
    end
    foreach (ex[k]) begin
      if (rf_card_model_i.wave.size() <= k * q + 2 || rf_card_model_i.wave[k * q + 2] !== ex[k]) begin
        bad++;
      end
    end
    check_count++;
    if (bad != 0) begin
      n_fail++;
      $display("FAIL %0t envelope wrong in %0d quarters", $time, bad);
    end
  endtask : cmp_wave

  // first and last pulses may be clipped, so only full runs and overlong runs count
  task automatic cmp_sc(input int h);
    int run;
    int good;
    int long_runs;
    run = 0;
    good = 0;
    long_runs = 0;
    foreach (rf_card_model_i.wave[k]) begin
      if (rf_card_model_i.wave[k] === 1'b1) begin
        run++;
      end else begin
        good += (run == h);
        long_runs += (run > h);
        run = 0;
      end
    end
    check_count++;
    if (good < 10 || long_runs != 0) begin
      n_fail++;
      $display("FAIL %0t subcarrier pulses %0d long %0d", $time, good, long_runs);
    end
  endtask : cmp_sc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge ref_clk_in);
    cmp8(reg_rdata_out, exp);
  endtask : rd

  task automatic cfg(input logic [7:0] f, input logic [7:0] x, input logic [7:0] c);
    wr(ADDR_FRAMING, f);
    wr(ADDR_AUX, x);
    wr(ADDR_CODING, c);
    fr = f;
    aux = x;
    cd = c;
  endtask : cfg

  function automatic int qlen(input logic [2:0] r);
    case (r)
      RATE_CODE_53: return QTR_RELOAD_53 + 1;
      RATE_CODE_106: return QTR_RELOAD_106 + 1;
      RATE_CODE_212: return QTR_RELOAD_212 + 1;
      RATE_CODE_424: return QTR_RELOAD_424 + 1;
      RATE_CODE_848: return QTR_RELOAD_848 + 1;
      default: return QTR_RELOAD_26 + 1;
    endcase
  endfunction : qlen

  function automatic void add(input logic v, input int n);
    repeat (n) ex.push_back(v);
  endfunction : add

  // expected quarter-bit envelope of one byte under the bench copies
  function automatic void build(input logic [7:0] b);
    logic [3:0] s;
    logic bits[$];
    int v;
    s = cd[7:4];
    for (int i = 0; i < 8; i++) bits.push_back(fr[7] ? b[7 - i] : b[i]);
    if (s == SCH_1OF4) begin
      for (int k = 0; k < 4; k++) begin
        v = {bits[2 * k + 1], bits[2 * k]};
        for (int j = 0; j < 4; j++) add(j == v, 4);
      end
    end else if (s >= SCH_256 && s <= SCH_256_LAST) begin
      v = (b == 8'h00 && s == SCH_256_LAST) ? 255 : b;
      for (int j = 0; j < 256; j++) add(j == v && !(b == 8'h00 && s == SCH_256_SILENT), 4);
    end else begin
      if (fr[0]) bits.push_front(fr[1]);
      if (aux[AUX_PARITY_EN]) bits.push_back(^b ^ fr[5]);
      if (aux[AUX_STOP_EN]) bits.push_back(fr[3]);
      foreach (bits[i]) begin
        if (s == SCH_PIE) begin
          add(1'b1, bits[i] ? 3 : 1);
          add(1'b0, 1);
        end else if (s >= SCH_RZ_FIRST && s <= SCH_RZ_LAST) begin
          for (int j = 0; j < 4; j++) add(bits[i] && j == s - 4, 1);
        end else begin
          add(bits[i], 4);
        end
      end
    end
  endfunction : build

  // valid is held across byte ends, so queued bytes go out back to back
  task automatic send(input logic [7:0] bs[$], input bit chk);
    logic ok;
    int t;
    ex.delete();
    rf_card_model_i.wave.delete();
    @(posedge ref_clk_in);
    foreach (bs[i]) begin
      build(bs[i]);
      byte_in <= bs[i];
      byte_valid_in <= 1'b1;
      t = 0;
      do begin
        @(negedge ref_clk_in);
        ok = byte_ready_out;
        @(posedge ref_clk_in);
        t++;
      end while (ok !== 1'b1 && t < 30000);
    end
    byte_valid_in <= 1'b0;
    rd(ADDR_AUX, (aux & AUX_WR_MASK) | 8'h80);
    t = 0;
    while (tx_active_out !== 1'b0 && t < 30000) begin
      @(posedge ref_clk_in);
      t++;
    end
    repeat (3) @(posedge ref_clk_in);
    cmp8({7'h00, tx_active_out}, 8'h00);
    if (chk) cmp_wave(qlen(cd[2:0]));
  endtask : send

  // main sequence
  initial begin
    logic [7:0] bs[$];
    int r;
    r = $urandom(32'hd448);
    repeat (10) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    rd(ADDR_FRAMING, FRAMING_RST);
    rd(ADDR_CODING, CODING_RST);
    wr(ADDR_FRAMING, 8'hff);
    rd(ADDR_FRAMING, FRAMING_WR_MASK);
    rd(8'h47, 8'h00);
    // clock enable low freezes everything: no ready, and a write is lost
    @(posedge ref_clk_in);
    clk_en_in <= 1'b0;
    @(negedge ref_clk_in);
    cmp8({7'h00, byte_ready_out}, 8'h00);
    wr(ADDR_CODING, 8'h5a);
    clk_en_in <= 1'b1;
    rd(ADDR_CODING, CODING_RST);
    // every rate, subcarrier select set but its envelope gate off
    for (int k = 2; k < 8; k++) begin
      cfg(8'h00, 8'h00, {SCH_PLAIN, 1'b1, 3'(k)});
      bs = {8'($urandom)};
      send(bs, 1'b1);
    end
    // random framing over every framed scheme, reserved codes kept out
    for (int k = 0; k < 14; k++) begin
      cfg(8'($urandom) & FRAMING_WR_MASK, 8'($urandom) & 8'h03, {sch[k % 7], 1'b0, RATE_CODE_848});
      bs = {8'($urandom), 8'($urandom)};
      send(bs, 1'b1);
    end
    for (int m = 0; m < 2; m++) begin
      cfg({1'(m), 7'h00}, 8'h00, {SCH_1OF4, 1'b0, RATE_CODE_848});
      bs = {8'h1b, 8'($urandom)};
      send(bs, 1'b1);
    end
    cfg(8'h00, 8'h00, {SCH_256, 1'b0, RATE_CODE_848});
    bs = {8'h00, 8'hff};
    send(bs, 1'b1);
    cfg(8'h00, 8'h00, {SCH_256_SILENT, 1'b0, RATE_CODE_848});
    bs = {8'h00, 8'($urandom)};
    send(bs, 1'b1);
    cfg(8'h00, 8'h00, {SCH_256_LAST, 1'b0, RATE_CODE_848});
    bs = {8'h00};
    send(bs, 1'b1);
    // subcarrier envelope on: pulse width follows the selected rate
    for (int f = 0; f < 2; f++) begin
      cfg(8'h00, 8'h04, {SCH_PLAIN, 1'(f), RATE_CODE_212});
      bs = {8'hff};
      send(bs, 1'b0);
      cmp_sc(f ? SC_RELOAD_848 + 1 : SC_RELOAD_424 + 1);
    end
    wrap_up();
  end
endmodule : tb
`default_nettype wire
